// ---- common/cfa_pkg.sv ----
package cfa_pkg;

	// Register bus carriers; AXI4-Lite signal names kept as published.
	typedef struct packed {
		logic [11:0] awaddr;
		logic awvalid;
		logic [31:0] wdata;
		logic [3:0] wstrb;
		logic wvalid;
		logic bready;
		logic [11:0] araddr;
		logic arvalid;
		logic rready;
	} cfa_axi_req_type;

	typedef struct packed {
		logic awready;
		logic wready;
		logic [1:0] bresp;
		logic bvalid;
		logic arready;
		logic [31:0] rdata;
		logic [1:0] rresp;
		logic rvalid;
	} cfa_axi_rsp_type;

	localparam logic [1:0] CFA_RESP_OKAY = 2'h0;
	localparam logic [1:0] CFA_RESP_SLVERR = 2'h2;

	// Register indexes; the byte address is four times the index.
	localparam logic [9:0] CFA_IDX_IN_CFG = 10'h010;
	localparam logic [9:0] CFA_IDX_OUT_CFG = 10'h014;
	localparam logic [9:0] CFA_IDX_EXT_MATCH = 10'h018;
	localparam logic [9:0] CFA_IDX_EXT_MASK = 10'h019;
	localparam logic [9:0] CFA_IDX_STATUS = 10'h01a;
	localparam logic [9:0] CFA_IDX_LINK_CFG = 10'h040;
	localparam logic [9:0] CFA_IDX_RX_CFG = 10'h069;
	localparam logic [9:0] CFA_IDX_TX_CFG = 10'h071;

	// Port configuration fields (input and output registers share a layout).
	localparam int CFA_B_MASTER = 0;
	localparam int CFA_B_NARROW = 1;
	localparam int CFA_B_ADDRESSED = 2;
	localparam int CFA_B_H5 = 3;
	localparam int CFA_B_PRE_LO = 4;
	localparam int CFA_B_HDR_SEL = 6;
	localparam int CFA_B_CSD = 7;
	// Link configuration fields.
	localparam int CFA_B_USR_LO = 0;
	localparam int CFA_B_CHECK = 4;
	localparam int CFA_B_LPRE = 5;
	localparam int CFA_B_FAR_NARROW = 6;
	localparam int CFA_B_FAR_CSD = 7;
	// Serial port fields.
	localparam int CFA_B_DELIN_DIS = 0;
	localparam int CFA_B_UNFRAMED = 1;
	localparam int CFA_B_HCS_PASS = 0;

	localparam logic [7:0] CFA_PORT_CFG_RST = 8'h08;
	localparam logic [7:0] CFA_LINK_CFG_RST = 8'h06;
	localparam logic [7:0] CFA_ZERO_RST = 8'h00;

	// Cell length figures in bytes.
	localparam logic [6:0] CFA_BASE_CELL = 7'h35;
	localparam logic [6:0] CFA_UDF_BYTES = 7'h01;
	localparam logic [6:0] CFA_ADDR8_BYTES = 7'h01;
	localparam logic [6:0] CFA_ADDR16_BYTES = 7'h02;
	localparam logic [6:0] CFA_PRE_BYTES = 7'h02;
	localparam logic [1:0] CFA_PRE8_CODE = 2'h2;
	localparam logic [1:0] CFA_PRE16_CODE = 2'h1;
	localparam logic [6:0] CFA_LINK_SYS = 7'h05;
	localparam logic [6:0] CFA_LINK_PAYLOAD = 7'h30;
	localparam logic [6:0] CFA_LINK_PRE_BYTES = 7'h02;
	localparam logic [6:0] CFA_LINK_CHECK_BYTES = 7'h02;
	localparam logic [2:0] CFA_HDR_ALL = 3'h5;
	localparam logic [2:0] CFA_HDR_NO_CHECK = 3'h4;

	typedef enum logic [2:0] {
		CFA_CTL_FIXED_ADDR = 3'b000,
		CFA_CTL_PREPEND = 3'b001,
		CFA_CTL_HEADER = 3'b010,
		CFA_CTL_HEADER_BYTE_INCLUDE = 3'b011,
		CFA_CTL_UNDEF = 3'b100,
		CFA_CTL_PAYLOAD = 3'b101
	} cfa_ctl_class_type;

endpackage

// ---- hdl/cfa_cell_format_adapter.sv ----
// What this block does
// RULE_01: Master port carries 53 bytes or 27 words.
// RULE_02: Single-PHY slave output proxies 32 channels.
// RULE_03: Header select puts channel into H5 byte.
// RULE_04: Prepend code adds two bytes or one word.
// RULE_05: Header include bit zero omits H5 field; the code keeps the H5 field on the output port when header select is in force.
// RULE_06: Addressed mode ignores header select bit.
// RULE_07: Addressed input matches base via match/mask.
// RULE_08: Output address word appends extended match value.
// RULE_09: Default input cell lengths 53, 54, 56.
// RULE_10: Default slave output lengths 54 and 56.
// RULE_11: UDF undefined or stripped across bus widths.
// RULE_12: Serial data port cells always 53 bytes.
// RULE_13: Serial receive delineates by default, disable bit.
// RULE_14: Serial transmit generates header check by default.
// RULE_15: Unframed serial data keeps all five header bytes.
// RULE_16: Control cell byte map fixed per position.
// RULE_17: Link carries channel address in extra word.
// RULE_18: Link format settings match on both ends.
// RULE_19: Default link cell is 59 bytes.
// RULE_20: Header select valid only for far single-PHY.
// RULE_21: Leave link prepend off to save bandwidth.
//
// Chosen here: the AXI4-Lite register port.
module cfa_cell_format_adapter
	import cfa_pkg::*;
#(
	parameter int ADDR_W = 12
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire cfa_axi_req_type axi_req,
	output cfa_axi_rsp_type axi_rsp,
	input wire logic in_addr_valid,
	input wire logic [ADDR_W-1:0] in_addr,
	output logic in_addr_hit,
	output logic [4:0] in_chan,
	input wire logic out_chan_valid,
	input wire logic [4:0] out_chan,
	output logic [15:0] out_addr_word,
	output logic [7:0] out_h5_byte,
	output logic out_addr_in_h5,
	input wire logic [5:0] ctl_byte_idx,
	output cfa_ctl_class_type ctl_byte_class,
	output logic [6:0] in_cell_len,
	output logic [6:0] out_cell_len,
	output logic [6:0] out_cell_units,
	output logic [6:0] link_cell_len,
	output logic udf_undefined,
	output logic udf_stripped,
	output logic rx_delineation_en,
	output logic tx_header_check_gen,
	output logic [2:0] hdr_bytes_carried
);

	logic [7:0] in_cfg_ff;
	logic [7:0] out_cfg_ff;
	logic [7:0] ext_match_ff;
	logic [7:0] ext_mask_ff;
	logic [7:0] link_cfg_ff;
	logic [7:0] rx_cfg_ff;
	logic [7:0] tx_cfg_ff;
	logic awready_ff;
	logic bvalid_ff;
	logic [1:0] bresp_ff;
	logic arready_ff;
	logic rvalid_ff;
	logic [31:0] rdata_ff;
	logic [1:0] rresp_ff;
	logic in_addr_hit_ff;
	logic [4:0] in_chan_ff;
	logic [15:0] out_addr_word_ff;
	logic [7:0] out_h5_byte_ff;
	logic out_addr_in_h5_ff;
	cfa_ctl_class_type ctl_class_ff;
	logic [6:0] in_len_ff;
	logic [6:0] out_len_ff;
	logic [6:0] out_units_ff;
	logic [6:0] link_len_ff;
	logic udf_undef_ff;
	logic udf_strip_ff;
	logic delin_ff;
	logic hcs_gen_ff;
	logic [2:0] hdr_carried_ff;
	logic [6:0] nxt_in_len;
	logic [6:0] nxt_out_len;
	logic [6:0] nxt_link_len;
	logic [31:0] nxt_rdata;
	logic wr_fire;
	logic rd_fire;
	logic wr_mapped;
	logic rd_mapped;
	logic out_hdr_sel_eff;

	// Indexes that hold a register answer OKAY, except writes to the read-only status index; the rest answer SLVERR.
	function automatic logic idx_mapped(input logic [9:0] idx);
		idx_mapped = (idx == CFA_IDX_IN_CFG) || (idx == CFA_IDX_OUT_CFG) ||
			(idx == CFA_IDX_EXT_MATCH) || (idx == CFA_IDX_EXT_MASK) ||
			(idx == CFA_IDX_STATUS) || (idx == CFA_IDX_LINK_CFG) ||
			(idx == CFA_IDX_RX_CFG) || (idx == CFA_IDX_TX_CFG);
	endfunction

	// Cell length on one parallel port, built from the base cell with bytes added or removed per field.
	function automatic logic [6:0] port_len(input logic [7:0] cfg, input logic is_out);
		logic narrow;
		logic addr_field;
		logic h5_field;
		logic hdr_sel;
		logic [6:0] len;
		narrow = cfg[CFA_B_NARROW];
		hdr_sel = is_out && cfg[CFA_B_HDR_SEL] && !cfg[CFA_B_ADDRESSED]; // see RULE_06
		h5_field = cfg[CFA_B_H5] || hdr_sel; // see RULE_05
		addr_field = cfg[CFA_B_ADDRESSED] ||
			(is_out && !cfg[CFA_B_MASTER] && !hdr_sel); // see RULE_02
		len = CFA_BASE_CELL;
		if (!narrow) begin
			len = len + CFA_UDF_BYTES; // see RULE_09
		end
		if (!h5_field) begin
			len = len - (narrow ? CFA_UDF_BYTES : (CFA_UDF_BYTES + CFA_UDF_BYTES));
		end
		if (addr_field) begin
			len = len + (narrow ? CFA_ADDR8_BYTES : CFA_ADDR16_BYTES); // see RULE_10
		end
		if ((narrow && cfg[CFA_B_PRE_LO +: 2] == CFA_PRE8_CODE) ||
			(!narrow && cfg[CFA_B_PRE_LO +: 2] == CFA_PRE16_CODE)) begin
			len = len + CFA_PRE_BYTES; // see RULE_04
		end
		if (cfg[CFA_B_CSD]) begin
			len = CFA_BASE_CELL; // see RULE_12
		end
		port_len = len;
	endfunction

	assign wr_fire = awready_ff && axi_req.awvalid && axi_req.wvalid;
	assign rd_fire = arready_ff && axi_req.arvalid;
	assign wr_mapped = idx_mapped(axi_req.awaddr[11:2]) && (axi_req.awaddr[11:2] != CFA_IDX_STATUS);
	assign rd_mapped = idx_mapped(axi_req.araddr[11:2]);
	assign out_hdr_sel_eff = out_cfg_ff[CFA_B_HDR_SEL] && !out_cfg_ff[CFA_B_ADDRESSED]; // see RULE_06

	// Lengths are recomputed from the stored settings every cycle.
	always_comb begin
		nxt_in_len = port_len(in_cfg_ff, 1'b0); // see RULE_09
		nxt_out_len = port_len(out_cfg_ff, 1'b1); // see RULE_10
		nxt_link_len = CFA_LINK_SYS + 7'(link_cfg_ff[CFA_B_USR_LO +: 4]) + CFA_LINK_PAYLOAD; // see RULE_19
		if (link_cfg_ff[CFA_B_LPRE]) begin
			nxt_link_len = nxt_link_len + CFA_LINK_PRE_BYTES; // see RULE_21
		end
		if (link_cfg_ff[CFA_B_CHECK]) begin
			nxt_link_len = nxt_link_len + CFA_LINK_CHECK_BYTES;
		end
	end

	// Read data mux; the status word shows the lengths in force.
	always_comb begin
		nxt_rdata = 32'h00000000;
		case (axi_req.araddr[11:2])
			CFA_IDX_IN_CFG: nxt_rdata = {24'h000000, in_cfg_ff};
			CFA_IDX_OUT_CFG: nxt_rdata = {24'h000000, out_cfg_ff};
			CFA_IDX_EXT_MATCH: nxt_rdata = {24'h000000, ext_match_ff};
			CFA_IDX_EXT_MASK: nxt_rdata = {24'h000000, ext_mask_ff};
			CFA_IDX_LINK_CFG: nxt_rdata = {24'h000000, link_cfg_ff};
			CFA_IDX_RX_CFG: nxt_rdata = {24'h000000, rx_cfg_ff};
			CFA_IDX_TX_CFG: nxt_rdata = {24'h000000, tx_cfg_ff};
			CFA_IDX_STATUS: nxt_rdata = {9'h000, link_len_ff, 1'b0, out_len_ff, 1'b0, in_len_ff};
			default: nxt_rdata = 32'h00000000;
		endcase
	end

	// Configuration registers; only byte lane 0 holds data.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			in_cfg_ff <= CFA_PORT_CFG_RST;
			out_cfg_ff <= CFA_PORT_CFG_RST;
			ext_match_ff <= CFA_ZERO_RST;
			ext_mask_ff <= CFA_ZERO_RST;
			link_cfg_ff <= CFA_LINK_CFG_RST; // see RULE_19
			rx_cfg_ff <= CFA_ZERO_RST;
			tx_cfg_ff <= CFA_ZERO_RST;
		end else if (wr_fire && axi_req.wstrb[0]) begin
			case (axi_req.awaddr[11:2])
				CFA_IDX_IN_CFG: in_cfg_ff <= axi_req.wdata[7:0];
				CFA_IDX_OUT_CFG: out_cfg_ff <= axi_req.wdata[7:0];
				CFA_IDX_EXT_MATCH: ext_match_ff <= axi_req.wdata[7:0];
				CFA_IDX_EXT_MASK: ext_mask_ff <= axi_req.wdata[7:0];
				CFA_IDX_LINK_CFG: link_cfg_ff <= axi_req.wdata[7:0]; // see RULE_18
				CFA_IDX_RX_CFG: rx_cfg_ff <= axi_req.wdata[7:0];
				CFA_IDX_TX_CFG: tx_cfg_ff <= axi_req.wdata[7:0];
				default: ;
			endcase
		end
	end

	// Write channel: address and data are taken together, one write at a time.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			awready_ff <= 1'b0;
			bvalid_ff <= 1'b0;
			bresp_ff <= CFA_RESP_OKAY;
		end else begin
			awready_ff <= axi_req.awvalid && axi_req.wvalid && !awready_ff && !bvalid_ff;
			if (wr_fire) begin
				bvalid_ff <= 1'b1;
				bresp_ff <= wr_mapped ? CFA_RESP_OKAY : CFA_RESP_SLVERR;
			end else if (axi_req.bready) begin
				bvalid_ff <= 1'b0;
			end
		end
	end

	// Read channel: the ready pulse is held off while a response is pending.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			arready_ff <= 1'b0;
			rvalid_ff <= 1'b0;
			rdata_ff <= 32'h00000000;
			rresp_ff <= CFA_RESP_OKAY;
		end else begin
			arready_ff <= axi_req.arvalid && !arready_ff && !rvalid_ff;
			if (rd_fire) begin
				rvalid_ff <= 1'b1;
				rdata_ff <= nxt_rdata;
				rresp_ff <= rd_mapped ? CFA_RESP_OKAY : CFA_RESP_SLVERR;
			end else if (axi_req.rready) begin
				rvalid_ff <= 1'b0;
			end
		end
	end

	// Format results follow the settings one cycle later.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			in_len_ff <= CFA_BASE_CELL;
			out_len_ff <= CFA_BASE_CELL;
			out_units_ff <= CFA_BASE_CELL;
			link_len_ff <= CFA_BASE_CELL;
			udf_undef_ff <= 1'b0;
			udf_strip_ff <= 1'b0;
			delin_ff <= 1'b1;
			hcs_gen_ff <= 1'b1;
			hdr_carried_ff <= CFA_HDR_NO_CHECK;
			out_addr_in_h5_ff <= 1'b0;
		end else begin
			in_len_ff <= nxt_in_len;
			out_len_ff <= nxt_out_len;
			// A wide port moves 16-bit words, so 54 bytes become 27 transfers.
			out_units_ff <= out_cfg_ff[CFA_B_NARROW] ? nxt_out_len : (nxt_out_len >> 1); // see RULE_01
			link_len_ff <= nxt_link_len; // see RULE_17
			udf_undef_ff <= !out_cfg_ff[CFA_B_NARROW] && !out_cfg_ff[CFA_B_CSD] &&
				(link_cfg_ff[CFA_B_FAR_NARROW] || link_cfg_ff[CFA_B_FAR_CSD]); // see RULE_11
			udf_strip_ff <= !link_cfg_ff[CFA_B_FAR_NARROW] && !link_cfg_ff[CFA_B_FAR_CSD] &&
				(out_cfg_ff[CFA_B_NARROW] || out_cfg_ff[CFA_B_CSD]); // see RULE_11
			delin_ff <= !rx_cfg_ff[CFA_B_DELIN_DIS]; // see RULE_13
			hcs_gen_ff <= !tx_cfg_ff[CFA_B_HCS_PASS]; // see RULE_14
			// Unframed data has no check byte to regenerate, so all five travel.
			hdr_carried_ff <= rx_cfg_ff[CFA_B_UNFRAMED] ? CFA_HDR_ALL : CFA_HDR_NO_CHECK; // see RULE_15
			out_addr_in_h5_ff <= out_hdr_sel_eff; // see RULE_03
		end
	end

	// Input address match: the upper bits locate the device, the low five pick a channel.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			in_addr_hit_ff <= 1'b0;
			in_chan_ff <= 5'h00;
		end else if (in_addr_valid) begin
			in_chan_ff <= in_addr[4:0];
			if (in_cfg_ff[CFA_B_ADDRESSED]) begin
				in_addr_hit_ff <= ((in_addr[ADDR_W-1:5] ^ (ADDR_W-5)'(ext_match_ff)) &
					(ADDR_W-5)'(ext_mask_ff)) == '0; // see RULE_07
			end else begin
				in_addr_hit_ff <= 1'b1;
			end
		end else begin
			in_addr_hit_ff <= 1'b0;
		end
	end

	// Output channel carriage: plain address word, H5 byte, or extended address word.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			out_addr_word_ff <= 16'h0000;
			out_h5_byte_ff <= 8'h00;
		end else if (out_chan_valid) begin
			if (out_cfg_ff[CFA_B_ADDRESSED]) begin
				out_addr_word_ff <= {ext_match_ff, 3'h0, out_chan}; // see RULE_08
				out_h5_byte_ff <= 8'h00;
			end else if (out_hdr_sel_eff) begin
				out_addr_word_ff <= 16'h0000;
				out_h5_byte_ff <= {3'h0, out_chan}; // see RULE_03
			end else begin
				out_addr_word_ff <= {11'h000, out_chan}; // see RULE_02
				out_h5_byte_ff <= 8'h00;
			end
		end
	end

	// Control cell byte map; bytes past the header section are payload.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ctl_class_ff <= CFA_CTL_FIXED_ADDR;
		end else begin
			case (ctl_byte_idx)
				6'h00, 6'h01: ctl_class_ff <= CFA_CTL_FIXED_ADDR; // see RULE_16
				6'h02, 6'h03: ctl_class_ff <= CFA_CTL_PREPEND; // see RULE_16
				6'h04, 6'h05, 6'h06, 6'h07: ctl_class_ff <= CFA_CTL_HEADER;
				6'h08, 6'h09: ctl_class_ff <= CFA_CTL_HEADER_BYTE_INCLUDE; // see RULE_16
				6'h0a, 6'h0b: ctl_class_ff <= CFA_CTL_UNDEF; // see RULE_16
				default: ctl_class_ff <= CFA_CTL_PAYLOAD;
			endcase
		end
	end

	// Every output is a flip-flop.
	assign axi_rsp.awready = awready_ff;
	assign axi_rsp.wready = awready_ff;
	assign axi_rsp.bresp = bresp_ff;
	assign axi_rsp.bvalid = bvalid_ff;
	assign axi_rsp.arready = arready_ff;
	assign axi_rsp.rdata = rdata_ff;
	assign axi_rsp.rresp = rresp_ff;
	assign axi_rsp.rvalid = rvalid_ff;
	assign in_addr_hit = in_addr_hit_ff;
	assign in_chan = in_chan_ff;
	assign out_addr_word = out_addr_word_ff;
	assign out_h5_byte = out_h5_byte_ff;
	assign out_addr_in_h5 = out_addr_in_h5_ff;
	assign ctl_byte_class = ctl_class_ff;
	assign in_cell_len = in_len_ff;
	assign out_cell_len = out_len_ff;
	assign out_cell_units = out_units_ff;
	assign link_cell_len = link_len_ff;
	assign udf_undefined = udf_undef_ff;
	assign udf_stripped = udf_strip_ff;
	assign rx_delineation_en = delin_ff;
	assign tx_header_check_gen = hcs_gen_ff;
	assign hdr_bytes_carried = hdr_carried_ff;

endmodule

// ---- verification/cfa_cell_format_adapter_chk.sv ----
module cfa_cell_format_adapter_chk
	import cfa_pkg::*;
#(
	parameter int ADDR_W = 12
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire cfa_axi_req_type axi_req,
	input wire cfa_axi_rsp_type axi_rsp,
	input wire logic in_addr_valid,
	input wire logic [ADDR_W-1:0] in_addr,
	input wire logic in_addr_hit,
	input wire logic [4:0] in_chan,
	input wire logic out_chan_valid,
	input wire logic [4:0] out_chan,
	input wire logic [15:0] out_addr_word,
	input wire logic [7:0] out_h5_byte,
	input wire logic out_addr_in_h5,
	input wire logic [5:0] ctl_byte_idx,
	input wire cfa_ctl_class_type ctl_byte_class,
	input wire logic [2:0] hdr_bytes_carried
);
	// One clock domain, so every check shares the clock and the reset.
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	property p_hit_idle; !in_addr_valid |=> !in_addr_hit; endproperty
	a_hit_idle: assert property (p_hit_idle) else $error("hit without strobe");
	property p_chan; in_addr_valid |=> in_chan == 5'($past(in_addr)); endproperty
	a_chan: assert property (p_chan) else $error("input channel wrong");
	property p_h5;
		out_chan_valid ##1 out_addr_in_h5 |-> out_addr_word == 16'h0 &&
			out_h5_byte == {3'h0, $past(out_chan)};
	endproperty
	a_h5: assert property (p_h5) else $error("channel not in header byte");
	property p_no_h5;
		out_chan_valid ##1 !out_addr_in_h5 |-> out_h5_byte == 8'h0 &&
			out_addr_word[4:0] == $past(out_chan);
	endproperty
	a_no_h5: assert property (p_no_h5) else $error("address word wrong");
	property p_ctl_fix; ctl_byte_idx < 6'h2 |=> ctl_byte_class == CFA_CTL_FIXED_ADDR; endproperty
	a_ctl_fix: assert property (p_ctl_fix) else $error("fixed address class");
	property p_ctl_h5; ctl_byte_idx inside {6'h8, 6'h9} |=> ctl_byte_class == CFA_CTL_HEADER_BYTE_INCLUDE; endproperty
	a_ctl_h5: assert property (p_ctl_h5) else $error("header byte class");
	property p_ctl_ud; ctl_byte_idx inside {6'ha, 6'hb} |=> ctl_byte_class == CFA_CTL_UNDEF; endproperty
	a_ctl_ud: assert property (p_ctl_ud) else $error("undefined class");
	property p_wr; axi_rsp.awready |=> axi_rsp.bvalid && !axi_rsp.awready; endproperty
	a_wr: assert property (p_wr) else $error("write response late");
	property p_rd; axi_rsp.arready |=> axi_rsp.rvalid && !axi_rsp.arready; endproperty
	a_rd: assert property (p_rd) else $error("read response late");
	property p_rhold; axi_rsp.rvalid && !axi_req.rready |=> axi_rsp.rvalid && $stable(axi_rsp.rdata); endproperty
	a_rhold: assert property (p_rhold) else $error("read data dropped");
	// The carried header count only moves in the cycle after a register write is answered.
	property p_hdr;
		(hdr_bytes_carried == CFA_HDR_ALL || hdr_bytes_carried == CFA_HDR_NO_CHECK) &&
			($changed(hdr_bytes_carried) -> $past(axi_rsp.bvalid));
	endproperty
	a_hdr: assert property (p_hdr) else $error("header byte count");

	// Main scenarios reached.
	c_hit: cover property (in_addr_valid ##1 in_addr_hit);
	c_h5: cover property (out_chan_valid ##1 out_addr_in_h5);
	c_wr: cover property (axi_rsp.bvalid && axi_req.bready);
endmodule

bind cfa_cell_format_adapter cfa_cell_format_adapter_chk #(.ADDR_W(ADDR_W)) i_chk (
	.aclk(aclk), .aresetn(aresetn), .axi_req(axi_req), .axi_rsp(axi_rsp),
	.in_addr_valid(in_addr_valid), .in_addr(in_addr), .in_addr_hit(in_addr_hit),
	.in_chan(in_chan), .out_chan_valid(out_chan_valid), .out_chan(out_chan),
	.out_addr_word(out_addr_word), .out_h5_byte(out_h5_byte),
	.out_addr_in_h5(out_addr_in_h5), .ctl_byte_idx(ctl_byte_idx),
	.ctl_byte_class(ctl_byte_class), .hdr_bytes_carried(hdr_bytes_carried)
);

// ---- verification/cfa_peer_model.sv ----
// Far cell bus: presents cell addresses and output channels one strobe at a time.
module cfa_peer_model (
	input wire logic aclk,
	output logic in_addr_valid,
	output logic [11:0] in_addr,
	output logic out_chan_valid,
	output logic [4:0] out_chan
);
	timeunit 1ns;
	timeprecision 1ps;

	// Idle lines at time zero.
	initial begin
		in_addr_valid = 1'b0;
		in_addr = 12'h0;
		out_chan_valid = 1'b0;
		out_chan = 5'h0;
	end

	// After the strobe the lines show the inverse, so a stale sample cannot pass.
	task send_in(input logic [11:0] a);
		@(posedge aclk);
		in_addr_valid <= 1'b1;
		in_addr <= a;
		@(posedge aclk);
		in_addr_valid <= 1'b0;
		in_addr <= ~a;
	endtask

	// Only single-PHY channels are offered when header select is used.
	task send_out(input logic [4:0] c);
		@(posedge aclk);
		out_chan_valid <= 1'b1;
		out_chan <= c;
		@(posedge aclk);
		out_chan_valid <= 1'b0;
		out_chan <= ~c;
	endtask
endmodule

// ---- verification/tb.sv ----
module tb
	import cfa_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic aclk = 1'b0;
	logic aresetn = 1'b0;
	cfa_axi_req_type req = '0;
	cfa_axi_rsp_type rsp;
	logic in_addr_valid, in_addr_hit, out_chan_valid, out_addr_in_h5;
	logic [11:0] in_addr;
	logic [4:0] in_chan, out_chan;
	logic [15:0] out_addr_word;
	logic [7:0] out_h5_byte;
	logic [5:0] ctl_byte_idx = 6'h0;
	cfa_ctl_class_type ctl_byte_class;
	logic [6:0] in_cell_len, out_cell_len, out_cell_units, link_cell_len;
	logic udf_undefined, udf_stripped, rx_delineation_en, tx_header_check_gen;
	logic [2:0] hdr_bytes_carried;
	logic [6:0] obs [8];
	logic [1:0] resp;
	logic [31:0] rd;
	int mismatches = 0;
	int checked = 0;
	cfa_ctl_class_type ecls;

	// Half period of 2.5 ns gives 200 MHz.
	always #2.5 aclk = ~aclk;

	// Observed levels selected by index in the configuration checks.
	assign obs = '{in_cell_len, out_cell_len, out_cell_units, link_cell_len,
		{5'h0, udf_undefined, udf_stripped}, {5'h0, rx_delineation_en, tx_header_check_gen},
		{4'h0, hdr_bytes_carried}, {6'h0, out_addr_in_h5}};

	cfa_cell_format_adapter #(.ADDR_W(12)) i_cfa_cell_format_adapter (
		.aclk(aclk), .aresetn(aresetn), .axi_req(req), .axi_rsp(rsp),
		.in_addr_valid(in_addr_valid), .in_addr(in_addr), .in_addr_hit(in_addr_hit),
		.in_chan(in_chan), .out_chan_valid(out_chan_valid), .out_chan(out_chan),
		.out_addr_word(out_addr_word), .out_h5_byte(out_h5_byte),
		.out_addr_in_h5(out_addr_in_h5), .ctl_byte_idx(ctl_byte_idx),
		.ctl_byte_class(ctl_byte_class), .in_cell_len(in_cell_len),
		.out_cell_len(out_cell_len), .out_cell_units(out_cell_units),
		.link_cell_len(link_cell_len), .udf_undefined(udf_undefined),
		.udf_stripped(udf_stripped), .rx_delineation_en(rx_delineation_en),
		.tx_header_check_gen(tx_header_check_gen), .hdr_bytes_carried(hdr_bytes_carried)
	);

	cfa_peer_model i_cfa_peer_model (
		.aclk(aclk), .in_addr_valid(in_addr_valid), .in_addr(in_addr),
		.out_chan_valid(out_chan_valid), .out_chan(out_chan)
	);

	task results;
		$display("checked %0d mismatches %0d", checked, mismatches);
		if (mismatches == 0 && checked > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	task chk(input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			mismatches++;
			$display("MISMATCH at %0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	// Write: address and data offered together, each released when taken.
	task wr(input logic [9:0] idx, input logic [7:0] d);
		int n;
		@(posedge aclk);
		req.awaddr <= {idx, 2'h0};
		req.wdata <= {24'h0, d};
		req.wstrb <= 4'hf;
		req.awvalid <= 1'b1;
		req.wvalid <= 1'b1;
		req.bready <= 1'b1;
		for (n = 0; n < 50 && rsp.bvalid !== 1'b1; n++) begin
			@(posedge aclk);
			if (rsp.awready === 1'b1) begin
				req.awvalid <= 1'b0;
				req.wvalid <= 1'b0;
			end
		end
		if (n == 50) begin
			mismatches++;
			results();
		end
		req.bready <= 1'b0;
		resp = rsp.bresp;
	endtask

	task rdr(input logic [9:0] idx);
		int n;
		@(posedge aclk);
		req.araddr <= {idx, 2'h0};
		req.arvalid <= 1'b1;
		req.rready <= 1'b1;
		for (n = 0; n < 50 && rsp.rvalid !== 1'b1; n++) begin
			@(posedge aclk);
			if (rsp.arready === 1'b1)
				req.arvalid <= 1'b0;
		end
		if (n == 50) begin
			mismatches++;
			results();
		end
		req.rready <= 1'b0;
		rd = rsp.rdata;
		resp = rsp.rresp;
	endtask

	// Write one register, let the derived levels settle, compare one of them.
	task cfg(input logic [9:0] idx, input logic [7:0] d, input int sel, input logic [6:0] exp);
		wr(idx, d);
		repeat (2) @(posedge aclk);
		chk(obs[sel], exp);
	endtask

	initial begin
		repeat (10) @(posedge aclk);
		aresetn <= 1'b1;
		rdr(CFA_IDX_IN_CFG);
		chk(rd, 32'h8);
		chk(resp, CFA_RESP_OKAY);
		rdr(CFA_IDX_LINK_CFG);
		chk(rd, 32'h6);
		rdr(CFA_IDX_RX_CFG);
		chk(rd, 32'h0);
		chk({in_cell_len, out_cell_len, link_cell_len}, {7'h36, 7'h38, 7'h3b});
		chk({rx_delineation_en, tx_header_check_gen, hdr_bytes_carried}, 5'h1c);
		rdr(10'h3ff);
		chk(resp, CFA_RESP_SLVERR);
		wr(CFA_IDX_STATUS, 8'h0);
		chk(resp, CFA_RESP_SLVERR);
		$display("test defaults done");
		cfg(CFA_IDX_IN_CFG, 8'h0b, 0, 7'h35);
		cfg(CFA_IDX_IN_CFG, 8'h0a, 0, 7'h35);
		cfg(CFA_IDX_IN_CFG, 8'h0e, 0, 7'h36);
		cfg(CFA_IDX_IN_CFG, 8'h09, 0, 7'h36);
		cfg(CFA_IDX_IN_CFG, 8'h0c, 0, 7'h38);
		cfg(CFA_IDX_IN_CFG, 8'h2a, 0, 7'h37);
		cfg(CFA_IDX_IN_CFG, 8'h18, 0, 7'h38);
		cfg(CFA_IDX_IN_CFG, 8'h02, 0, 7'h34);
		cfg(CFA_IDX_IN_CFG, 8'h04, 0, 7'h36);
		cfg(CFA_IDX_IN_CFG, 8'h88, 0, 7'h35);
		rdr(CFA_IDX_STATUS);
		chk(rd & 32'h7f, 32'h35);
		cfg(CFA_IDX_OUT_CFG, 8'h0a, 1, 7'h36);
		cfg(CFA_IDX_OUT_CFG, 8'h0b, 1, 7'h35);
		cfg(CFA_IDX_OUT_CFG, 8'h09, 2, 7'h1b);
		cfg(CFA_IDX_OUT_CFG, 8'h48, 1, 7'h36);
		$display("test lengths done");
		cfg(CFA_IDX_OUT_CFG, 8'h0a, 7, 7'h0);
		i_cfa_peer_model.send_out(5'h1f);
		@(posedge aclk);
		chk(out_addr_word, 16'h001f);
		cfg(CFA_IDX_OUT_CFG, 8'h4a, 7, 7'h1);
		i_cfa_peer_model.send_out(5'h13);
		@(posedge aclk);
		chk({out_addr_word, out_h5_byte}, 24'h000013);
		cfg(CFA_IDX_OUT_CFG, 8'h4c, 7, 7'h0);
		cfg(CFA_IDX_EXT_MATCH, 8'h55, 1, 7'h38);
		i_cfa_peer_model.send_out(5'h07);
		@(posedge aclk);
		chk(out_addr_word, 16'h5507);
		cfg(CFA_IDX_IN_CFG, 8'h0c, 0, 7'h38);
		wr(CFA_IDX_EXT_MATCH, 8'h2a);
		wr(CFA_IDX_EXT_MASK, 8'h7f);
		chk(resp, CFA_RESP_OKAY);
		i_cfa_peer_model.send_in({7'h2a, 5'h07});
		@(posedge aclk);
		chk({in_addr_hit, in_chan}, 6'h27);
		i_cfa_peer_model.send_in({7'h2b, 5'h03});
		@(posedge aclk);
		chk(in_addr_hit, 1'b0);
		wr(CFA_IDX_EXT_MASK, 8'h7e);
		i_cfa_peer_model.send_in({7'h2b, 5'h03});
		@(posedge aclk);
		chk({in_addr_hit, in_chan}, 6'h23);
		$display("test addressing done");
		cfg(CFA_IDX_LINK_CFG, 8'h26, 3, 7'h3d);
		cfg(CFA_IDX_LINK_CFG, 8'h16, 3, 7'h3d);
		cfg(CFA_IDX_LINK_CFG, 8'h05, 3, 7'h3a);
		cfg(CFA_IDX_OUT_CFG, 8'h08, 1, 7'h38);
		cfg(CFA_IDX_LINK_CFG, 8'h46, 4, 7'h2);
		cfg(CFA_IDX_OUT_CFG, 8'h0a, 4, 7'h0);
		cfg(CFA_IDX_LINK_CFG, 8'h06, 4, 7'h1);
		cfg(CFA_IDX_OUT_CFG, 8'h88, 4, 7'h1);
		cfg(CFA_IDX_RX_CFG, 8'h01, 5, 7'h1);
		cfg(CFA_IDX_TX_CFG, 8'h01, 5, 7'h0);
		cfg(CFA_IDX_RX_CFG, 8'h02, 6, 7'h5);
		cfg(CFA_IDX_RX_CFG, 8'h00, 5, 7'h2);
		$display("test link and serial done");
		// Sweep control cell positions, including the first payload bytes.
		for (int i = 0; i < 16; i++) begin
			ctl_byte_idx <= 6'(i);
			repeat (2) @(posedge aclk);
			ecls = i < 2 ? CFA_CTL_FIXED_ADDR : i < 4 ? CFA_CTL_PREPEND : i < 8 ? CFA_CTL_HEADER :
				i < 10 ? CFA_CTL_HEADER_BYTE_INCLUDE : i < 12 ? CFA_CTL_UNDEF : CFA_CTL_PAYLOAD;
			chk(ctl_byte_class, ecls);
		end
		$display("test control cell done");
		results();
	end
endmodule
